// >>> ecos_output_switch.sv
// Overview of operation
// [RL1] Position cams compare against the position counter
// [RL2] Forward inhibit flag ignores forward-counting crossings
// [RL3] Reverse inhibit flag ignores backward-counting crossings
// [RL4] Reference zero compares thresholds with counter
// [RL5] Reference two compares with measured frequency
// [RL6] Auto enable overrides host commanded output level
// [RL7] Enabling keeps last state, else FALSE
// [RL8] Only first N thresholds are active
// [RL9] Frequency mode uses thresholds one and two
// [RL10] Count one hysteresis, count two window
// [RL11] Zero on-time holds level until next
// [RL12] Nonzero on-time in microseconds, restarts on hit
// [RL13] Eight 32-bit thresholds, zero valid
// [RL14] Only counting pulses switch, presets never
// [RL15] Output level sampled each host cycle
`timescale 1ns/10ps
`default_nettype none
module ecos_output_switch #(
  parameter int unsigned NUM_THR = ecos_pkg::NUM_THR,
  parameter int unsigned THR_W = ecos_pkg::THR_W
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Encoder side
  input wire logic [THR_W-1:0] counter_value_in,
  input wire logic count_pulse_in,
  input wire logic count_forward_in,
  input wire logic preset_load_in,
  input wire logic [THR_W-1:0] freq_value_in,
  // Host process-data cycle strobe
  input wire logic host_cycle_in,
  // Digital output
  output logic switch_out
);
  localparam int unsigned DUR_W = ecos_pkg::DUR_W;
  localparam int unsigned CNT_W = ecos_pkg::CNT_W;
  localparam int unsigned IDX_W = $clog2(NUM_THR);

  // Configuration registers
  logic auto_en_q;
  logic forward_compare_inhibit_q;
  logic reverse_compare_inhibit_q;
  logic manual_level_q;
  logic [1:0] ref_sel_q;
  logic [CNT_W-1:0] active_compare_count_q;
  logic [NUM_THR-1:0] level_q;
  logic [THR_W-1:0] thr_q [NUM_THR];
  logic [DUR_W-1:0] dur_q [NUM_THR];
  // Output state
  logic auto_q;
  logic auto_d;
  logic switch_q;
  logic output_level_readback_q;
  // Bus state
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // Address phase decode
  wire logic acc_w = hsel && hready && htrans[1];
  wire logic [7:0] a_w = haddr[7:0];
  wire logic tbl_thr_w = (a_w & ecos_pkg::OFS_TBL_MASK) == ecos_pkg::OFS_THR;
  wire logic tbl_dur_w = (a_w & ecos_pkg::OFS_TBL_MASK) == ecos_pkg::OFS_DUR;
  wire logic [IDX_W-1:0] a_idx_w = a_w[IDX_W+1:2];
  wire logic [IDX_W-1:0] w_idx_w = wr_addr_q[IDX_W+1:2];
  wire logic w_thr_w = (wr_addr_q & ecos_pkg::OFS_TBL_MASK) == ecos_pkg::OFS_THR;
  wire logic w_dur_w = (wr_addr_q & ecos_pkg::OFS_TBL_MASK) == ecos_pkg::OFS_DUR;
  wire logic w_ctrl_w = wr_addr_q == ecos_pkg::OFS_CTRL;
  wire logic w_lvl_w = wr_addr_q == ecos_pkg::OFS_LEVELS;
  // Duration writes above the ceiling are clamped
  wire logic [DUR_W-1:0] wdur_w = (hwdata > 32'(ecos_pkg::DUR_MAX_US)) ?
      ecos_pkg::DUR_MAX_US : hwdata[DUR_W-1:0];

  // Zero wait states; every access answers OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  // Mode decode
  wire logic ref_cnt_w = ref_sel_q == ecos_pkg::REF_COUNTER;
  wire logic ref_freq_w = ref_sel_q == ecos_pkg::REF_FREQ;
  wire logic dir_ok_w = count_forward_in ? !forward_compare_inhibit_q
                                         : !reverse_compare_inhibit_q;

  // Per-slot equality matches
  logic [NUM_THR-1:0] match_w;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_THR; gi++) begin : g_cell
      ecos_cmp_cell #(
        .INDEX(gi),
        .THR_W(THR_W),
        .CNT_W(CNT_W)
      ) u_cell (
        .value_in(counter_value_in),
        .threshold_in(thr_q[gi]),
        .active_count_in(active_compare_count_q),
        .match_out(match_w[gi])
      ); // see [RL8] see [RL13]
    end
  endgenerate

  // Lowest matching slot wins when thresholds coincide
  logic [IDX_W-1:0] hit_idx_w;
  always_comb begin
    hit_idx_w = '0;
    for (int i = NUM_THR - 1; i >= 0; i--) begin
      if (match_w[i]) begin
        hit_idx_w = IDX_W'(i);
      end
    end
  end

  // Presets never strobe count_pulse_in, so they cannot switch
  wire logic cnt_hit_w = ref_cnt_w && count_pulse_in && dir_ok_w && (|match_w); // see [RL1] see [RL4] see [RL14]
  wire logic [DUR_W-1:0] hit_dur_w = dur_q[hit_idx_w];
  wire logic hit_level_w = level_q[hit_idx_w];

  // Timed-cam timer
  logic tmr_busy_w;
  logic tmr_expire_w;
  ecos_us_timer #(
    .DUR_W(DUR_W),
    .PRE_W(ecos_pkg::PRE_W),
    .US_CYCLES(ecos_pkg::US_CYCLES)
  ) u_timer (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .load_in(cnt_hit_w), // see [RL12]
    .length_us_in(hit_dur_w),
    .busy_out(tmr_busy_w),
    .expire_out(tmr_expire_w)
  );

  // Frequency comparisons on the first two slots only
  wire logic [THR_W-1:0] f0_w = thr_q[0];
  wire logic [THR_W-1:0] f1_w = thr_q[1];
  wire logic f_ge0_w = freq_value_in >= f0_w;
  wire logic f_le0_w = freq_value_in <= f0_w;
  wire logic f_ge1_w = freq_value_in >= f1_w;
  wire logic f_le1_w = freq_value_in <= f1_w;
  wire logic pos_hyst_w = f0_w >= f1_w;
  wire logic pos_win_w = f0_w < f1_w;
  wire logic hyst_on_w = pos_hyst_w ? f_ge0_w : f_le0_w;
  wire logic hyst_off_w = pos_hyst_w ? f_le1_w : f_ge1_w;
  // Window: inside for positive logic, outside for negative
  wire logic win_w = pos_win_w ? (f_ge0_w && !f_ge1_w) : !(f_le0_w && !f_le1_w);
  wire logic use_hyst_w = active_compare_count_q == ecos_pkg::CNT_HYST;
  wire logic use_win_w = active_compare_count_q >= ecos_pkg::CNT_TWO;

  // Next automatic level; auto_q survives disabling for a clean restart
  always_comb begin
    auto_d = auto_q;
    if (ref_cnt_w) begin
      if (cnt_hit_w) begin
        auto_d = hit_level_w; // see [RL11]
      end else if (tmr_expire_w) begin
        auto_d = !auto_q; // see [RL12]
      end
    end else if (ref_freq_w) begin
      if (use_win_w) begin
        auto_d = win_w; // see [RL9] see [RL10]
      end else if (use_hyst_w && hyst_on_w) begin
        auto_d = 1'b1; // see [RL5] see [RL10]
      end else if (use_hyst_w && hyst_off_w) begin
        auto_d = 1'b0;
      end
    end
  end

  // Output state; reset value FALSE covers the no-history case
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      auto_q <= 1'b0;
      switch_q <= 1'b0;
      output_level_readback_q <= 1'b0;
    end else begin
      auto_q <= auto_d; // see [RL7]
      switch_q <= auto_en_q ? auto_q : manual_level_q; // see [RL6]
      if (host_cycle_in) begin
        output_level_readback_q <= switch_q; // see [RL15]
      end
    end
  end
  assign switch_out = switch_q;

  // Register read mux, sampled in the address phase
  always_comb begin
    rdata_d = '0;
    if (tbl_thr_w) begin
      rdata_d = thr_q[a_idx_w];
    end else if (tbl_dur_w) begin
      rdata_d = 32'(dur_q[a_idx_w]);
    end else if (a_w == ecos_pkg::OFS_CTRL) begin
      rdata_d[ecos_pkg::CTRL_AUTO] = auto_en_q;
      rdata_d[ecos_pkg::CTRL_FWD_INH] = forward_compare_inhibit_q;
      rdata_d[ecos_pkg::CTRL_REV_INH] = reverse_compare_inhibit_q;
      rdata_d[ecos_pkg::CTRL_MANUAL] = manual_level_q;
      rdata_d[ecos_pkg::CTRL_REF_LO +: 2] = ref_sel_q;
      rdata_d[ecos_pkg::CTRL_CNT_LO +: CNT_W] = active_compare_count_q;
    end else if (a_w == ecos_pkg::OFS_STATUS) begin
      rdata_d[ecos_pkg::STAT_READBACK] = output_level_readback_q;
      rdata_d[ecos_pkg::STAT_LIVE] = switch_q;
      rdata_d[ecos_pkg::STAT_TIMER] = tmr_busy_w;
      rdata_d[ecos_pkg::STAT_AUTO] = auto_q;
    end else if (a_w == ecos_pkg::OFS_LEVELS) begin
      rdata_d[NUM_THR-1:0] = level_q;
    end
  end

  // Bus phase tracking; only 0x00-0x5f decode, the rest read zero
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      rdata_q <= '0;
    end else begin
      wr_pend_q <= acc_w && hwrite;
      if (acc_w) begin
        wr_addr_q <= a_w;
      end
      if (acc_w && !hwrite) begin
        rdata_q <= (haddr[31:8] == '0) ? rdata_d : '0;
      end
    end
  end

  // Control and level writes in the data phase
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      auto_en_q <= 1'b0;
      forward_compare_inhibit_q <= 1'b0;
      reverse_compare_inhibit_q <= 1'b0;
      manual_level_q <= 1'b0;
      ref_sel_q <= ecos_pkg::REF_COUNTER;
      active_compare_count_q <= '0;
      level_q <= '0;
    end else if (wr_pend_q && w_ctrl_w) begin
      auto_en_q <= hwdata[ecos_pkg::CTRL_AUTO];
      forward_compare_inhibit_q <= hwdata[ecos_pkg::CTRL_FWD_INH]; // see [RL2]
      reverse_compare_inhibit_q <= hwdata[ecos_pkg::CTRL_REV_INH]; // see [RL3]
      manual_level_q <= hwdata[ecos_pkg::CTRL_MANUAL];
      ref_sel_q <= hwdata[ecos_pkg::CTRL_REF_LO +: 2];
      active_compare_count_q <= hwdata[ecos_pkg::CTRL_CNT_LO +: CNT_W];
    end else if (wr_pend_q && w_lvl_w) begin
      level_q <= hwdata[NUM_THR-1:0];
    end
  end

  // Threshold and on-time tables
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < NUM_THR; i++) begin
        thr_q[i] <= '0;
        dur_q[i] <= '0;
      end
    end else if (wr_pend_q && w_thr_w) begin
      thr_q[w_idx_w] <= hwdata[THR_W-1:0];
    end else if (wr_pend_q && w_dur_w) begin
      dur_q[w_idx_w] <= wdur_w;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  chk_auto_drives: assert property (auto_en_q |=> switch_q == $past(auto_q)) // see [RL6]
    else $error("auto mode output does not follow threshold logic");
  chk_manual_drives: assert property (!auto_en_q |=> switch_q == $past(manual_level_q))
    else $error("manual level not applied");
  chk_fwd_inhibit: assert property (ref_cnt_w && count_pulse_in && count_forward_in // see [RL2]
      && forward_compare_inhibit_q && !tmr_expire_w |=> auto_q == $past(auto_q))
    else $error("forward crossing switched while inhibited");
  chk_rev_inhibit: assert property (ref_cnt_w && count_pulse_in && !count_forward_in // see [RL3]
      && reverse_compare_inhibit_q && !tmr_expire_w |=> auto_q == $past(auto_q))
    else $error("reverse crossing switched while inhibited");
  chk_preset_quiet: assert property (ref_cnt_w && preset_load_in && !count_pulse_in // see [RL14]
      && !tmr_expire_w |=> auto_q == $past(auto_q))
    else $error("preset load switched the output");
  chk_cam_level: assert property (cnt_hit_w |=> auto_q == $past(hit_level_w)) // see [RL1]
    else $error("cam hit did not apply slot level");
  chk_slot_active: assert property (cnt_hit_w |-> 32'(hit_idx_w) < 32'(active_compare_count_q)) // see [RL8]
    else $error("inactive slot switched the output");
  chk_ontime_start: assert property (cnt_hit_w && hit_dur_w != '0 |=> tmr_busy_w [*2]) // see [RL12]
    else $error("on-time not started");
  chk_cam_hold: assert property (cnt_hit_w && hit_dur_w == '0 |=> !tmr_busy_w) // see [RL11]
    else $error("zero on-time left timer running");
  chk_hyst_on: assert property (ref_freq_w && use_hyst_w && pos_hyst_w && f_ge0_w // see [RL10]
      |=> auto_q)
    else $error("hysteresis did not switch on");
  chk_freq_window: assert property (ref_freq_w && use_win_w |=> auto_q == $past(win_w)) // see [RL9]
    else $error("frequency window level wrong");
  chk_readback_sample: assert property (host_cycle_in |=> output_level_readback_q // see [RL15]
      == $past(switch_q))
    else $error("readback not sampled");
  cov_cam_hit: cover property (cnt_hit_w ##1 switch_q != $past(switch_q));
  cov_time_cam: cover property (cnt_hit_w && hit_dur_w != '0 ##[1:1000] tmr_expire_w);
  cov_freq_switch: cover property (ref_freq_w && auto_en_q ##1 $rose(auto_q));
endmodule
`default_nettype wire

// >>> ecos_pkg.sv
package ecos_pkg;
  // Threshold table geometry
  localparam int unsigned NUM_THR = 8;
  localparam int unsigned THR_W = 32;
  localparam int unsigned DUR_W = 15;
  localparam int unsigned CNT_W = 4;
  localparam logic [DUR_W-1:0] DUR_MAX_US = 15'd24000;
  // Timing: on-time is counted in microseconds
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned US_NS = 1000;
  localparam int unsigned US_CYCLES = US_NS / CLK_PERIOD_NS;
  localparam int unsigned PRE_W = 7;
  // Reference source codes
  localparam logic [1:0] REF_COUNTER = 2'h0;
  localparam logic [1:0] REF_FREQ = 2'h2;
  // Frequency-mode compare counts
  localparam logic [CNT_W-1:0] CNT_HYST = 4'h1;
  localparam logic [CNT_W-1:0] CNT_TWO = 4'h2;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_LEVELS = 8'h08;
  localparam logic [7:0] OFS_THR = 8'h20;
  localparam logic [7:0] OFS_DUR = 8'h40;
  localparam logic [7:0] OFS_TBL_MASK = 8'he0;
  // Control register fields
  localparam int unsigned CTRL_AUTO = 0;
  localparam int unsigned CTRL_FWD_INH = 1;
  localparam int unsigned CTRL_REV_INH = 2;
  localparam int unsigned CTRL_MANUAL = 3;
  localparam int unsigned CTRL_REF_LO = 4;
  localparam int unsigned CTRL_CNT_LO = 8;
  // Status register fields
  localparam int unsigned STAT_READBACK = 0;
  localparam int unsigned STAT_LIVE = 1;
  localparam int unsigned STAT_TIMER = 2;
  localparam int unsigned STAT_AUTO = 3;
endpackage

// >>> ecos_cmp_cell.sv
`timescale 1ns/10ps
`default_nettype none
// One threshold slot: equality match gated by the active count
module ecos_cmp_cell #(
  parameter int unsigned INDEX = 0,
  parameter int unsigned THR_W = 32,
  parameter int unsigned CNT_W = 4
) (
  // Compare operands
  input wire logic [THR_W-1:0] value_in,
  input wire logic [THR_W-1:0] threshold_in,
  // Number of slots in use
  input wire logic [CNT_W-1:0] active_count_in,
  // Result
  output logic match_out
);
  localparam logic [CNT_W-1:0] SLOT = CNT_W'(INDEX);
  // Zero is a legal threshold, so no special case for it
  assign match_out = (value_in == threshold_in) && (SLOT < active_count_in);
endmodule
`default_nettype wire

// >>> ecos_us_timer.sv
`timescale 1ns/10ps
`default_nettype none
// Microsecond down-counter for timed cams
module ecos_us_timer #(
  parameter int unsigned DUR_W = 15,
  parameter int unsigned PRE_W = 7,
  parameter int unsigned US_CYCLES = 125
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Load: a zero length simply stops the timer
  input wire logic load_in,
  input wire logic [DUR_W-1:0] length_us_in,
  // State
  output logic busy_out,
  output logic expire_out
);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(US_CYCLES - 1);
  localparam logic [DUR_W-1:0] ONE_US = DUR_W'(1);
  logic [PRE_W-1:0] pre_q;
  logic [DUR_W-1:0] left_q;
  logic tick_w;
  logic done_w;
  // Prescaler restarts with each load so the first microsecond is whole
  assign tick_w = busy_out && (pre_q == PRE_LAST);
  assign done_w = tick_w && (left_q == ONE_US);
  assign busy_out = (left_q != '0);
  // Pulse one cycle at the end of the on-time
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pre_q <= '0;
      left_q <= '0;
      expire_out <= 1'b0;
    end else begin
      expire_out <= done_w && !load_in;
      if (load_in) begin
        pre_q <= '0;
        left_q <= length_us_in;
      end else if (busy_out) begin
        pre_q <= tick_w ? '0 : pre_q + PRE_W'(1);
        if (tick_w) begin
          left_q <= left_q - ONE_US;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> ecos_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// Host controller: writes settings, reads status words
module ecos_host_model (
  // Clock
  input wire logic core_clk_in,
  // AHB-Lite master side
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // Select stays high, so back-to-back transfers never retoggle it
  initial begin
    hsel = 1'b1;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end
  // Next edge with hready high, bounded; flags a hang
  task automatic wait_rdy(inout bit late);
    int n;
    n = 0;
    @(posedge core_clk_in);
    while (hready !== 1'b1 && n < 64) begin
      n++;
      @(posedge core_clk_in);
    end
    late = late | (hready !== 1'b1);
  endtask
  // One whole-word transfer; call just after a rising edge
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, inout bit late);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    wait_rdy(late);
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy(late);
    rd = hrdata;
  endtask
endmodule
`default_nettype wire

// >>> test_encoder_cam_output_switch.sv
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for the cam output switch
module test_encoder_cam_output_switch;
  // Bus, encoder and output signals
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] cnt_val = 32'h0000_0000;
  logic pulse = 1'b0;
  logic fwd = 1'b1;
  logic preset = 1'b0;
  logic [31:0] freq = 32'h0000_0000;
  logic host_cyc = 1'b0;
  logic sw;
  int err_total = 0;
  int n_tests = 0;
  logic [31:0] thr [3];
  logic [31:0] rdv;
  logic [31:0] f;
  logic hys;

  // 125 MHz core clock
  always #4 core_clk_in = ~core_clk_in;

  ecos_output_switch dut_u (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .counter_value_in(cnt_val),
    .count_pulse_in(pulse),
    .count_forward_in(fwd),
    .preset_load_in(preset),
    .freq_value_in(freq),
    .host_cycle_in(host_cyc),
    .switch_out(sw)
  );
  ecos_host_model host_u (
    .core_clk_in(core_clk_in),
    .hready(hreadyout),
    .hrdata(hrdata),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata)
  );

  // Result comparisons
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Verdict, the only exit
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic hang_abort();
    err_total++;
    final_report();
  endtask
  // Register access; a stuck bus ends the run
  task automatic acc(input logic w, input logic [7:0] ofs, input logic [31:0] wd);
    bit late;
    late = 1'b0;
    host_u.xfer(w, {24'h00_0000, ofs}, wd, rdv, late);
    if (late) begin
      hang_abort();
    end
  endtask
  task automatic rchk(input logic [7:0] ofs, input logic [31:0] exp, input string what);
    acc(1'b0, ofs, 32'h0000_0000);
    cmp_word(what, exp, rdv);
  endtask
  // Control word: flags are manual, reverse, forward, auto
  function automatic logic [31:0] ctl(input logic [3:0] fl, input logic [1:0] rs, input logic [3:0] c);
    return {20'h0_0000, c, 2'b00, rs, fl};
  endfunction
  // Wait n edges, then sample off the edge
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  // Counting pulse; output judged two edges after it is taken
  task automatic step(input logic [31:0] v, input logic dir, input logic exp, input string what);
    cnt_val <= v;
    fwd <= dir;
    pulse <= 1'b1;
    @(posedge core_clk_in);
    pulse <= 1'b0;
    settle(2);
    cmp_bit(what, exp, sw);
  endtask

  // Main sequence
  initial begin
    void'($urandom(53036));
    thr[0] = 32'h0000_0000;
    for (int i = 1; i < 3; i++) begin
      thr[i] = ($urandom() & 32'hFFFF_FFFC) | 32'(i);
    end
    settle(16);
    rst_in <= 1'b0;
    settle(1);
    cmp_bit("reset output", 1'b0, sw);
    rchk(ecos_pkg::OFS_CTRL, 32'h0000_0000, "reset ctrl");
    rchk(ecos_pkg::OFS_STATUS, 32'h0000_0000, "reset status");
    acc(1'b1, 8'h60, 32'hFFFF_FFFF);
    rchk(8'h60, 32'h0000_0000, "unmapped");
    cmp_bit("hresp", 1'b0, hresp);
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, ecos_pkg::OFS_THR + 8'(4 * i), thr[i]);
    end
    rchk(ecos_pkg::OFS_THR + 8'h04, thr[1], "threshold");
    acc(1'b1, ecos_pkg::OFS_LEVELS, 32'h0000_0001);
    acc(1'b1, ecos_pkg::OFS_CTRL, ctl(4'h1, ecos_pkg::REF_COUNTER, 4'h2));
    settle(3);
    cmp_bit("enable no state", 1'b0, sw);
    step(thr[0], 1'b1, 1'b1, "zero cam");
    step(thr[2], 1'b1, 1'b1, "slot over count");
    step(thr[1], 1'b0, 1'b0, "cam off");
    step(thr[1] + 32'h0000_0001, 1'b1, 1'b0, "no match");
    cnt_val <= thr[0];
    preset <= 1'b1;
    @(posedge core_clk_in);
    preset <= 1'b0;
    settle(3);
    cmp_bit("preset", 1'b0, sw);
    acc(1'b1, ecos_pkg::OFS_CTRL, ctl(4'h8, ecos_pkg::REF_COUNTER, 4'h2));
    settle(3);
    cmp_bit("manual", 1'b1, sw);
    acc(1'b1, ecos_pkg::OFS_CTRL, ctl(4'h9, ecos_pkg::REF_COUNTER, 4'h2));
    settle(3);
    cmp_bit("auto over manual", 1'b0, sw);
    // Each inhibit flag in turn: blocked direction first
    for (int d = 0; d < 2; d++) begin
      acc(1'b1, ecos_pkg::OFS_CTRL, ctl(4'h1 | (4'h2 << d), ecos_pkg::REF_COUNTER, 4'h2));
      step(thr[0], d == 0, 1'b0, "inhibited on");
      step(thr[0], d != 0, 1'b1, "allowed on");
      step(thr[1], d == 0, 1'b1, "inhibited off");
      step(thr[1], d != 0, 1'b0, "allowed off");
    end
    acc(1'b1, ecos_pkg::OFS_LEVELS, 32'h0000_0005);
    acc(1'b1, ecos_pkg::OFS_CTRL, ctl(4'h1, ecos_pkg::REF_COUNTER, 4'h3));
    step(thr[2], 1'b1, 1'b1, "third slot");
    step(thr[1], 1'b1, 1'b0, "held until next");
    // Timed cams of 2 us, the second restarting the first
    acc(1'b1, ecos_pkg::OFS_LEVELS, 32'h0000_0003);
    acc(1'b1, ecos_pkg::OFS_DUR, 32'h0000_0002);
    acc(1'b1, ecos_pkg::OFS_DUR + 8'h04, 32'h0000_0002);
    step(thr[0], 1'b1, 1'b1, "timed on");
    settle(150);
    step(thr[1], 1'b1, 1'b1, "timed restart");
    settle(200);
    cmp_bit("timer restarted", 1'b1, sw);
    settle(60);
    cmp_bit("timer expired", 1'b0, sw);
    acc(1'b1, ecos_pkg::OFS_DUR, 32'h0000_FFFF);
    rchk(ecos_pkg::OFS_DUR, {17'h0_0000, ecos_pkg::DUR_MAX_US}, "duration clamp");
    acc(1'b1, ecos_pkg::OFS_DUR, 32'h0000_0000);
    step(thr[0], 1'b1, 1'b1, "cam on");
    rchk(ecos_pkg::OFS_STATUS, 32'h0000_000A, "status before sample");
    host_cyc <= 1'b1;
    @(posedge core_clk_in);
    host_cyc <= 1'b0;
    @(posedge core_clk_in);
    rchk(ecos_pkg::OFS_STATUS, 32'h0000_000B, "status sampled");
    // Frequency window, count 2 and count 3 alike
    acc(1'b1, ecos_pkg::OFS_THR, 32'h0000_0064);
    acc(1'b1, ecos_pkg::OFS_THR + 8'h04, 32'h0000_00C8);
    acc(1'b1, ecos_pkg::OFS_THR + 8'h08, 32'h0000_0096);
    for (int c = 2; c < 4; c++) begin
      acc(1'b1, ecos_pkg::OFS_CTRL, ctl(4'h1, ecos_pkg::REF_FREQ, 4'(c)));
      for (int k = 0; k < 10; k++) begin
        f = (k < 4) ? 32'(99 + k % 2 + 100 * (k / 2)) : $urandom_range(300);
        freq <= f;
        settle(4);
        cmp_bit("freq window", f >= 100 && f < 200, sw);
      end
    end
    // Hysteresis: on at 200 or more, off at 100 or less
    acc(1'b1, ecos_pkg::OFS_THR, 32'h0000_00C8);
    acc(1'b1, ecos_pkg::OFS_THR + 8'h04, 32'h0000_0064);
    acc(1'b1, ecos_pkg::OFS_CTRL, ctl(4'h1, ecos_pkg::REF_FREQ, 4'h1));
    hys = 1'b0;
    for (int k = 0; k < 14; k++) begin
      f = (k < 4) ? 32'(50 + 50 * k) : $urandom_range(300);
      hys = (f >= 200) ? 1'b1 : (f <= 100) ? 1'b0 : hys;
      freq <= f;
      settle(4);
      cmp_bit("freq hysteresis", hys, sw);
    end
    final_report();
  end
endmodule
`default_nettype wire
